// [lfc_chk.sv]
// Checker for the line format control block, watching its ports only.
// Assumes it is bound to uart_line_format_control with one clock domain.
`timescale 1ns/1ps
module lfc_chk
    import lfc_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic serial_rx_in,
    input wire logic [7:0] rdata,
    input wire logic serial_tx_out,
    input wire logic rx_parity_error
);
    // ****************************************
    // Shadow registers
    // ****************************************
    logic [7:0] lfc_q; // Format register copy
    logic [7:0] ier_q; // Interrupt enable copy
    logic [7:0] div_lo_q; // Divisor low byte
    logic [7:0] efr_q; // Enhanced feature copy
    // Follow host writes into the format register and one register of each mode
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lfc_q <= LFC_RESET;
            ier_q <= 8'h00;
            div_lo_q <= DIV_RESET[7:0];
            efr_q <= 8'h00;
        end
        else if (wr_en)
        begin
            if (addr == ADDR_LFC) lfc_q <= wdata;
            if (addr == ADDR_IER && !lfc_q[BIT_DIV_ACCESS]) ier_q <= wdata;
            if (addr == ADDR_DATA && lfc_q[BIT_DIV_ACCESS]) div_lo_q <= wdata;
            if (addr == ADDR_ALT && lfc_q == LFC_ENHANCED_KEY) efr_q <= wdata;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    AST_BREAK_LOW: assert property (lfc_q[BIT_BREAK] && $past(lfc_q[BIT_BREAK]) |-> !serial_tx_out)
        else $error("break set but line not low");
    AST_TX_RESET_HIGH: assert property ($rose(arst_n) |-> serial_tx_out)
        else $error("line not high after reset");
    AST_READ_FORMAT: assert property (rd_en && !wr_en && addr == ADDR_LFC |=> rdata == $past(lfc_q))
        else $error("format readback wrong");
    AST_FLOW_HIDDEN: assert property (rd_en && addr >= ADDR_XON1 && lfc_q != LFC_ENHANCED_KEY |=> rdata == 8'h00)
        else $error("flow character visible outside key");
    AST_PERR_NEEDS_EN: assert property ($rose(rx_parity_error) |-> lfc_q[BIT_PAR_EN])
        else $error("parity error without parity enable");
    AST_IER_READ: assert property (rd_en && !wr_en && addr == ADDR_IER && !lfc_q[BIT_DIV_ACCESS]
        |=> rdata == $past(ier_q))
        else $error("ordinary register readback wrong");
    AST_DIV_READ: assert property (rd_en && !wr_en && addr == ADDR_DATA && lfc_q[BIT_DIV_ACCESS]
        |=> rdata == $past(div_lo_q))
        else $error("divisor readback wrong");
    AST_EFR_READ: assert property (rd_en && !wr_en && addr == ADDR_ALT && lfc_q == LFC_ENHANCED_KEY
        |=> rdata == $past(efr_q))
        else $error("enhanced feature readback wrong");
endmodule : lfc_chk

bind uart_line_format_control lfc_chk chk (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .serial_rx_in(serial_rx_in), .rdata(rdata),
    .serial_tx_out(serial_tx_out), .rx_parity_error(rx_parity_error));

// [lfc_parity_unit.sv]
// Parity generation and checking for one character.
// Assumes the character is presented as an 8-bit word with its length in bits.
`timescale 1ns/1ps
module lfc_parity_unit
    import lfc_pkg::*;
(
    input wire logic [7:0] data,
    input wire logic [3:0] nbits,
    input wire logic par_en,
    input wire logic par_type,
    input wire logic par_force,
    input wire logic rx_par_bit,
    output logic par_active,
    output logic par_bit,
    output logic par_err
);
    // ****************************************
    // Parity value
    // ****************************************
    always_comb
    begin
        logic x;
        x = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (i < int'(nbits))
            begin
                x = x ^ data[i];
            end
        end
        par_active = par_en;
        if (par_force)
        begin
            par_bit = ~par_type;
        end
        else
        begin
            par_bit = par_type ? x : ~x; // Even or odd
        end
        par_err = par_en && (rx_par_bit != par_bit);
    end
endmodule : lfc_parity_unit

// [lfc_pkg.sv]
// Constants for the line format control block of one UART channel.
// Assumes an 8-bit host bus with a 3-bit channel address, write and read strobes.
package lfc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [2:0] ADDR_DATA = 3'h0;     // Holding regs / divisor low
    localparam logic [2:0] ADDR_IER = 3'h1;      // Interrupt enable / divisor high
    localparam logic [2:0] ADDR_ALT = 3'h2;      // Fifo control / enhanced feature
    localparam logic [2:0] ADDR_LFC = 3'h3;      // Line format control
    localparam logic [2:0] ADDR_XON1 = 3'h4;     // Flow character 1
    localparam logic [2:0] ADDR_XON2 = 3'h5;     // Flow character 2
    localparam logic [2:0] ADDR_XOFF1 = 3'h6;    // Flow character 3
    localparam logic [2:0] ADDR_XOFF2 = 3'h7;    // Flow character 4
    // ****************************************
    // Line format control fields
    // ****************************************
    localparam int BIT_DIV_ACCESS = 7;
    localparam int BIT_BREAK = 6;
    localparam int BIT_PAR_FORCE = 5;
    localparam int BIT_PAR_TYPE = 4;
    localparam int BIT_PAR_EN = 3;
    localparam logic [7:0] LFC_RESET = 8'h00;
    localparam logic [7:0] LFC_ENHANCED_KEY = 8'hBF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [15:0] BAUD_OVERSAMPLE = 16'h0010;
endpackage : lfc_pkg

// [lfc_remote.sv]
// Remote serial terminal: sends frames to the block and captures its frames.
// Assumes divisor one, so one bit lasts 16 mclk cycles; line idles high.
`timescale 1ns/1ps
module lfc_remote (
    input wire logic mclk,
    input wire logic serial_tx_out,
    output logic serial_rx_in
);
    localparam int BIT_CYC = 16; // Cycles per bit
    initial serial_rx_in = 1'h1; // Idle at mark
    // Drive one bit for a full bit time
    task automatic put(input logic b);
        #1 serial_rx_in = b;
        repeat (BIT_CYC) @(posedge mclk);
    endtask : put
    // Start, eight data bits LSB first, optional parity, one stop
    task automatic send(input logic [7:0] d, input logic hp, input logic p);
        put(1'h0);
        for (int i = 0; i < 8; i++) put(d[i]);
        if (hp) put(p);
        put(1'h1);
    endtask : send
    // Capture data and the bit after it at bit centres
    task automatic get(output logic [7:0] d, output logic nb);
        int n;
        n = 0;
        while (serial_tx_out !== 1'h0 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
        repeat (BIT_CYC / 2) @(negedge mclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYC) @(negedge mclk);
            d[i] = serial_tx_out;
        end
        repeat (BIT_CYC) @(negedge mclk);
        nb = serial_tx_out;
    endtask : get
endmodule : lfc_remote

// [uart_line_format_control.sv]
// One UART channel with its line format control register.
// Assumes synchronous host strobes on mclk; the serial receive pin is asynchronous.
`timescale 1ns/1ps
module uart_line_format_control
    import lfc_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic serial_rx_in,
    output logic [7:0] rdata,
    output logic serial_tx_out,
    output logic rx_parity_error
);
    // ****************************************
    // Registers
    // ****************************************
    typedef enum logic [3:0] {IDLE = 4'b0001, START = 4'b0010, BITS = 4'b0100, STOP = 4'b1000} txs_t;
    logic [7:0] line_format_control_q;        // Format register
    logic [15:0] divisor_q;                    // Baud divisor latch
    logic [7:0] ier_q;                         // Interrupt enable store
    logic [7:0] enhanced_feature_reg_q;        // Enhanced features
    logic [7:0] flow_char_q [4];               // Flow control characters
    logic [7:0] tx_hold_q;                     // Holding byte
    logic tx_pend_q;                           // Holding byte waiting
    logic [7:0] rx_hold_q;                     // Last received byte
    logic [15:0] baud_cnt_q;                   // Tick divider
    logic tick_q;                              // Oversample tick
    txs_t tx_state_q;                          // Transmit state
    logic [7:0] tx_shift_q;                    // Transmit shift
    logic [3:0] tx_idx_q;                      // Bit index
    logic [3:0] tx_sub_q;                      // Oversample phase
    logic tx_line_q;                           // Transmitter line level
    logic [1:0] rx_sync_q;                     // Receive pin synchroniser
    logic rx_busy_q;                           // Receiving a character
    logic [3:0] rx_sub_q;
    logic [3:0] rx_idx_q;
    logic [7:0] rx_shift_q;
    wire div_access = line_format_control_q[BIT_DIV_ACCESS];
    wire enhanced = (line_format_control_q == LFC_ENHANCED_KEY);
    wire [3:0] nbits = 4'(5 + int'(line_format_control_q[1:0]));
    wire tx_par_act, tx_par_bit, rx_par_act, rx_par_err;
    // ****************************************
    // Parity units
    // ****************************************
    lfc_parity_unit u_tx_par (.data(tx_shift_q), .nbits(nbits), .par_en(line_format_control_q[BIT_PAR_EN]),
        .par_type(line_format_control_q[BIT_PAR_TYPE]), .par_force(line_format_control_q[BIT_PAR_FORCE]),
        .rx_par_bit(1'b0), .par_active(tx_par_act), .par_bit(tx_par_bit), .par_err());
    lfc_parity_unit u_rx_par (.data(rx_shift_q), .nbits(nbits), .par_en(line_format_control_q[BIT_PAR_EN]),
        .par_type(line_format_control_q[BIT_PAR_TYPE]), .par_force(line_format_control_q[BIT_PAR_FORCE]),
        .rx_par_bit(rx_sync_q[1]), .par_active(rx_par_act), .par_bit(), .par_err(rx_par_err));
    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            line_format_control_q <= LFC_RESET;
            divisor_q <= DIV_RESET;
            ier_q <= REG_RESET;
            enhanced_feature_reg_q <= REG_RESET;
            for (int i = 0; i < 4; i++) flow_char_q[i] <= REG_RESET;
        end
        else if (wr_en)
        begin
            if (addr == ADDR_LFC)
            begin
                line_format_control_q <= wdata;
            end
            else if (enhanced)
            begin
                // Enhanced set
                if (addr == ADDR_ALT) enhanced_feature_reg_q <= wdata;
                else if (addr >= ADDR_XON1) flow_char_q[addr[1:0]] <= wdata;
                else if (addr == ADDR_DATA) divisor_q[7:0] <= wdata;
                else divisor_q[15:8] <= wdata;
            end
            else if (div_access)
            begin
                // Special set
                if (addr == ADDR_DATA) divisor_q[7:0] <= wdata;
                else if (addr == ADDR_IER) divisor_q[15:8] <= wdata;
            end
            else
            begin
                // Ordinary set
                if (addr == ADDR_IER) ier_q <= wdata;
            end
        end
    end
    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata <= 8'h00;
        end
        else if (rd_en)
        begin
            if (addr == ADDR_LFC) rdata <= line_format_control_q;
            else if (enhanced && addr == ADDR_ALT) rdata <= enhanced_feature_reg_q;
            else if (enhanced && addr >= ADDR_XON1) rdata <= flow_char_q[addr[1:0]];
            else if (div_access && addr == ADDR_DATA) rdata <= divisor_q[7:0];
            else if (div_access && addr == ADDR_IER) rdata <= divisor_q[15:8];
            else if (!div_access && addr == ADDR_DATA) rdata <= rx_hold_q;
            else if (!div_access && addr == ADDR_IER) rdata <= ier_q;
            else rdata <= 8'h00;
        end
    end
    // ****************************************
    // Holding byte
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_hold_q <= 8'h00;
            tx_pend_q <= 1'b0;
        end
        else if (wr_en && addr == ADDR_DATA && !div_access)
        begin
            tx_hold_q <= wdata;
            tx_pend_q <= 1'b1;
        end
        else if (tx_state_q == IDLE && tick_q)
        begin
            tx_pend_q <= 1'b0;
        end
    end
    // ****************************************
    // Baud tick divider
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            baud_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (baud_cnt_q == 16'h0000);
            baud_cnt_q <= (baud_cnt_q == 16'h0000) ? divisor_q - 16'h0001 : baud_cnt_q - 16'h0001;
        end
    end
    // ****************************************
    // Transmitter
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_state_q <= IDLE;
            tx_shift_q <= 8'h00;
            tx_idx_q <= 4'h0;
            tx_sub_q <= 4'h0;
            tx_line_q <= 1'b1;
        end
        else if (tick_q)
        begin
            tx_sub_q <= tx_sub_q + 4'h1;
            unique case (tx_state_q)
                IDLE:
                begin
                    tx_line_q <= 1'b1;
                    tx_sub_q <= 4'h0;
                    if (tx_pend_q)
                    begin
                        tx_shift_q <= tx_hold_q;
                        tx_state_q <= START;
                        tx_line_q <= 1'b0;
                    end
                end
                START:
                begin
                    if (tx_sub_q == 4'hF)
                    begin
                        tx_state_q <= BITS;
                        tx_idx_q <= 4'h0;
                        tx_line_q <= tx_shift_q[0];
                    end
                end
                BITS:
                begin
                    if (tx_sub_q == 4'hF)
                    begin
                        tx_idx_q <= tx_idx_q + 4'h1;
                        if (tx_idx_q + 4'h1 < nbits) tx_line_q <= tx_shift_q[tx_idx_q[2:0] + 3'h1];
                        else if (tx_idx_q + 4'h1 == nbits && tx_par_act) tx_line_q <= tx_par_bit;
                        else
                        begin
                            tx_line_q <= 1'b1;
                            tx_state_q <= STOP;
                        end
                    end
                end
                STOP:
                begin
                    if (tx_sub_q == 4'hF) tx_state_q <= IDLE;
                end
            endcase
        end
    end
    // ****************************************
    // Serial output with break override
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n) serial_tx_out <= 1'b1;
        else serial_tx_out <= line_format_control_q[BIT_BREAK] ? 1'b0 : tx_line_q;
    end
    // ****************************************
    // Receiver
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_sync_q <= 2'b11;
            rx_busy_q <= 1'b0;
            rx_sub_q <= 4'h0;
            rx_idx_q <= 4'h0;
            rx_shift_q <= 8'h00;
            rx_hold_q <= 8'h00;
            rx_parity_error <= 1'b0;
        end
        else
        begin
            rx_sync_q <= {rx_sync_q[0], serial_rx_in};
            if (tick_q)
            begin
                if (!rx_busy_q)
                begin
                    rx_sub_q <= 4'h0;
                    rx_idx_q <= 4'h0;
                    if (!rx_sync_q[1]) rx_busy_q <= 1'b1;
                end
                else
                begin
                    rx_sub_q <= rx_sub_q + 4'h1;
                    if (rx_sub_q == 4'h7 && rx_idx_q != 4'h0)
                    begin
                        // Sample mid bit; index 1.. holds data, then parity, then stop
                        if (rx_idx_q <= nbits) rx_shift_q[rx_idx_q[2:0] - 3'h1] <= rx_sync_q[1];
                        else if (rx_idx_q == nbits + 4'h1 && rx_par_act)
                            rx_parity_error <= rx_par_err;
                        else
                        begin
                            rx_busy_q <= 1'b0;
                            rx_hold_q <= rx_shift_q;
                        end
                    end
                    if (rx_sub_q == 4'hF) rx_idx_q <= rx_idx_q + 4'h1;
                end
            end
        end
    end
endmodule : uart_line_format_control

// [uart_line_format_control_tb.sv]
// Self-checking bench for the line format control block.
// Assumes the remote terminal model and the bound checker.
`timescale 1ns/1ps
module uart_line_format_control_tb
    import lfc_pkg::*;
;
    logic mclk = 1'h0;
    logic arst_n = 1'h0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'h0;
    logic rd_en = 1'h0;
    logic serial_rx_in;
    logic [7:0] rdata;
    logic serial_tx_out;
    logic rx_parity_error;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [7:0] d;
    logic b;
    // Formats with expected tx bit after data, rx parity sent, expected rx error
    // Seven-bit row: its parity fills the eighth captured slot, the next bit is stop
    logic [7:0] fmt [7] = '{8'h03, 8'h0B, 8'h0A, 8'h1B, 8'h2B, 8'h3B, 8'h33};
    logic txp [7] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1};
    logic rxp [7] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
    logic perr [7] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0};
    always #50 mclk = ~mclk;
    uart_line_format_control uut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .serial_rx_in(serial_rx_in), .rdata(rdata), .serial_tx_out(serial_tx_out),
        .rx_parity_error(rx_parity_error));
    lfc_remote remote (.mclk(mclk), .serial_tx_out(serial_tx_out), .serial_rx_in(serial_rx_in));
    // Verdict and end of run
    task automatic report_and_stop;
        $display("mismatches %0d compares %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One-cycle host write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        #1 addr = a;
        wdata = v;
        wr_en = 1'h1;
        @(posedge mclk);
        #1 wr_en = 1'h0;
    endtask : wr
    // Host read, data registered at the taking edge
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
        @(posedge mclk);
        #1 addr = a;
        rd_en = 1'h1;
        @(posedge mclk);
        #1 rd_en = 1'h0;
        chk(nm, e, rdata);
    endtask : rd
    // Hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        #1 arst_n = 1'h1;
        rd(ADDR_LFC, 8'h00, "fmt_reset");
        wr(ADDR_IER, 8'h05);
        wr(ADDR_LFC, 8'h80);
        rd(ADDR_LFC, 8'h80, "fmt_dlab");
        rd(ADDR_DATA, 8'h01, "div_low");
        rd(ADDR_IER, 8'h00, "div_high");
        wr(ADDR_DATA, 8'h02);
        rd(ADDR_DATA, 8'h02, "div_low_wr");
        wr(ADDR_DATA, 8'h01);
        wr(ADDR_IER, 8'h00);
        wr(ADDR_LFC, 8'h03);
        rd(ADDR_IER, 8'h05, "ier");
        wr(ADDR_LFC, 8'hBF);
        wr(ADDR_XON1, 8'h5A);
        wr(ADDR_ALT, 8'h10);
        rd(ADDR_XON1, 8'h5A, "flow_char");
        rd(ADDR_ALT, 8'h10, "efr");
        wr(ADDR_LFC, 8'h03);
        rd(ADDR_XON1, 8'h00, "flow_hidden");
        wr(ADDR_LFC, 8'h43);
        repeat (30)
        begin
            @(posedge mclk);
            #1 chk("tx_break", 8'h00, {7'h00, serial_tx_out});
        end
        wr(ADDR_LFC, 8'h03);
        repeat (2) @(posedge mclk);
        #1 chk("tx_idle", 8'h01, {7'h00, serial_tx_out});
        for (int i = 0; i < 7; i++)
        begin
            wr(ADDR_LFC, fmt[i]);
            wr(ADDR_DATA, 8'h01);
            remote.get(d, b);
            chk("tx_data", 8'h01, d);
            chk("tx_parity", {7'h00, txp[i]}, {7'h00, b});
            repeat (20) @(posedge mclk);
            remote.send(8'h01, fmt[i][BIT_PAR_EN], rxp[i]);
            repeat (4) @(posedge mclk);
            #1 chk("rx_perr", {7'h00, perr[i]}, {7'h00, rx_parity_error});
            rd(ADDR_DATA, 8'h01, "rx_data");
        end
        report_and_stop;
    end
endmodule : uart_line_format_control_tb
